// >>> core/rst_ctrl_pkg.sv
// constants, register map and state codes of the reset source controller
package rst_ctrl_pkg;

    // register offsets
    localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
    localparam logic [7:0] ADDR_AUX_ONE       = 8'ha2;
    localparam logic [7:0] ADDR_BOD_ZERO      = 8'ha3;
    localparam logic [7:0] ADDR_IRQ_STATUS    = 8'hb0;
    localparam logic [7:0] ADDR_IRQ_MASK      = 8'hb1;

    // field positions
    localparam int COLD_BIT      = 4;
    localparam int PD_BIT        = 1;
    localparam int PINF_BIT      = 6;
    localparam int BOD_EN_BIT    = 7;
    localparam int LVL_HI_BIT    = 6;
    localparam int LVL_LO_BIT    = 4;
    localparam int BOF_BIT       = 3;
    localparam int RST_EN_BIT    = 2;
    localparam int BOD_FLAG_BIT  = 1;
    localparam int BOS_BIT       = 0;
    localparam int IRQ_COLD_BIT  = 0;
    localparam int IRQ_BOD_BIT   = 1;
    localparam int IRQ_PIN_BIT   = 2;
    localparam int IRQ_LEVEL_BIT = 3;
    localparam int IRQ_W         = 4;

    // reset values and write masks
    localparam logic [7:0]        REG_RESET     = 8'h00;
    localparam logic [IRQ_W-1:0]  IRQ_RESET     = 4'h0;
    localparam logic [7:0]        PWR_WMASK     = 8'hdf;
    localparam logic [7:0]        COLD_MASK     = 8'h10;
    localparam logic [7:0]        AUX_WMASK     = 8'had;
    localparam logic [7:0]        PINF_MASK     = 8'h40;
    localparam logic [7:0]        BOD_WMASK     = 8'hfe;
    localparam logic [15:0]       RESTART_VECTOR = 16'h0000;

    // least low time of the reset pin, in system clock cycles
    localparam logic [4:0]        PIN_LOW_MIN_CYCLES = 5'h18;

    // width of the synchronised asynchronous input vector
    localparam int ASYNC_W = 11;

    typedef enum logic [5:0] {
        ST_POR  = 6'h01,
        ST_OSC  = 6'h02,
        ST_RUN  = 6'h04,
        ST_BOD  = 6'h08,
        ST_PIN  = 6'h10,
        ST_WAKE = 6'h20
    } seq_state_e;

endpackage

// >>> core/pin_status_if.sv
// synchronised reset pin status passed from the pin filter to the controller
`timescale 1ns/1ns
`default_nettype none
interface pin_status_if;
    logic pin_low;
    logic pin_valid;
    modport filter (output pin_low, output pin_valid);
    modport ctrl   (input  pin_low, input  pin_valid);
endinterface
`default_nettype wire

// >>> core/reset_pin_filter.sv
// two-flop synchroniser and low-time qualifier for the external reset pin
`timescale 1ns/1ns
`default_nettype none
module reset_pin_filter
    import rst_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic         clock_i,
    input  wire logic         rst_i,
    // pin
    input  wire logic         reset_pin_n_i,
    // status to controller
    pin_status_if.filter      pin_st
);

    logic       pin_meta_r;
    logic       pin_sync_r;
    logic [4:0] low_count_r;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pin_meta_r <= 1'b1;
            pin_sync_r <= 1'b1;
        end else begin
            pin_meta_r <= reset_pin_n_i;
            pin_sync_r <= pin_meta_r;
        end
    end

    // counts sampled low cycles, saturates at the qualifying length
    always_ff @(posedge clock_i) begin
        if (rst_i || pin_sync_r) begin
            low_count_r <= 5'h00;
        end else if (low_count_r != PIN_LOW_MIN_CYCLES) begin
            low_count_r <= low_count_r + 5'h01;
        end
    end

    assign pin_st.pin_low   = ~pin_sync_r;
    assign pin_st.pin_valid = (low_count_r == PIN_LOW_MIN_CYCLES);

    AST_PIN_QUALIFY: assert property (@(posedge clock_i) disable iff (rst_i)
        $fell(pin_sync_r) |-> !pin_st.pin_valid [*8])
        else $error("reset pin qualified too early");

endmodule
`default_nettype wire

// >>> core/reset_source_controller.sv
// reset sequencer with reset-cause flags and register port
//
// Function
// - three reset sources exist and any reset restores ordinary register bits while cause flags follow their source.
// - below the power-on threshold the core stays in reset, then the oscillator starts and fetch begins at 0000H.
// - completing a power-on reset sets the cold reset indicator, bit 4 of power control.
// - the cold reset indicator keeps its value across every reset other than power-on.
// - a supply at the brown-out level resets the device only while the brown-out reset enable, bit 2, is one.
// - a brown-out reset sets bit 1 of brown-out control zero, only power-on or brown-out reset alter it, software may write it.
// - the reset pin is sampled on the system clock and the internal reset follows the clock.
// - reset lasts while the pin is low and afterwards fetch restarts at 0000H.
// - a pin low in power-down restarts the clock and reset follows once the clock is stable.
// - a pin reset sets bit 6 of auxiliary one, only power-on or pin reset change it, software may clear it.
// - every reset reloads detect enable, level select and reset enable from config bits 7, 6 to 4 and 2.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module reset_source_controller
    import rst_ctrl_pkg::*;
(
    // clock and power-on reset
    input  wire logic         clock_i,
    input  wire logic         rst_i,
    // supply monitor, pin and configuration
    input  wire logic         supply_above_por_i,
    input  wire logic         supply_below_bod_i,
    input  wire logic         reset_pin_n_i,
    input  wire logic [7:0]   nonvolatile_config_byte_i,
    // oscillator
    input  wire logic         clock_stable_i,
    output logic              oscillator_start_o,
    output logic              clock_restart_o,
    // core
    output logic              core_reset_o,
    output logic              powerdown_o,
    output logic              fetch_start_o,
    output logic [15:0]       restart_vector_o,
    // register port
    input  wire logic [7:0]   reg_addr_i,
    input  wire logic [7:0]   reg_wdata_i,
    input  wire logic         reg_write_i,
    input  wire logic         reg_read_i,
    output logic [7:0]        reg_rdata_o,
    // interrupt
    output logic              irq_o
);

    pin_status_if ps ();

    reset_pin_filter u_pin (
        .clock_i       (clock_i),
        .rst_i         (rst_i),
        .reset_pin_n_i (reset_pin_n_i),
        .pin_st        (ps.filter)
    );

    seq_state_e             state_r;
    seq_state_e             state_nxt;
    logic [ASYNC_W-1:0]     async_meta_r;
    logic [ASYNC_W-1:0]     async_sync_r;
    logic [7:0]             pwr_ctrl_r;
    logic [7:0]             aux_r;
    logic [7:0]             bod_r;
    logic [IRQ_W-1:0]       status_r;
    logic [IRQ_W-1:0]       mask_r;
    logic [IRQ_W-1:0]       events;
    logic                   below_d_r;
    logic                   fetch_r;
    logic [7:0]             rdata_r;
    logic                   supply_ok_s;
    logic                   below_s;
    logic                   clock_stable_s;
    logic [7:0]             cfg_s;
    logic                   in_reset;
    logic                   bod_trip;
    logic                   bos;
    logic                   por_done;
    logic                   bod_done;
    logic                   pin_done;
    logic                   wr_ok;
    logic                   bod_flag_keep;

    // asynchronous inputs pass two flops
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            async_meta_r <= '0;
            async_sync_r <= '0;
        end else begin
            async_meta_r <= {nonvolatile_config_byte_i, clock_stable_i, supply_below_bod_i, supply_above_por_i};
            async_sync_r <= async_meta_r;
        end
    end

    assign supply_ok_s    = async_sync_r[0];
    assign below_s        = async_sync_r[1];
    assign clock_stable_s = async_sync_r[2];
    assign cfg_s          = async_sync_r[10:3];

    assign in_reset = (state_r != ST_RUN);
    assign bos      = bod_r[BOD_EN_BIT] & below_s;
    assign bod_trip = bos & bod_r[RST_EN_BIT];
    assign wr_ok    = reg_write_i & ~in_reset;

    // reset sequence
    always_comb begin
        state_nxt = state_r;
        if (!supply_ok_s) begin
            state_nxt = ST_POR;
        end else begin
            case (state_r)
                ST_POR: begin
                    state_nxt = ST_OSC;
                end
                ST_OSC: begin
                    if (clock_stable_s) begin
                        state_nxt = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (bod_trip) begin
                        state_nxt = ST_BOD;
                    end else if (pwr_ctrl_r[PD_BIT] && ps.pin_low) begin
                        state_nxt = ST_WAKE;
                    end else if (ps.pin_valid) begin
                        state_nxt = ST_PIN;
                    end
                end
                ST_BOD: begin
                    if (!below_s) begin
                        state_nxt = ST_RUN;
                    end
                end
                ST_PIN: begin
                    if (!ps.pin_low) begin
                        state_nxt = ST_RUN;
                    end
                end
                ST_WAKE: begin
                    if (clock_stable_s) begin
                        state_nxt = ST_PIN;
                    end
                end
                default: begin
                    state_nxt = ST_POR;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state_r <= ST_POR;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign por_done = (state_r == ST_OSC) && (state_nxt == ST_RUN);
    assign bod_done = (state_r == ST_BOD) && (state_nxt == ST_RUN);
    assign pin_done = (state_r == ST_PIN) && (state_nxt == ST_RUN);

    // fetch restart pulse at the restart vector
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            fetch_r <= 1'b0;
        end else begin
            fetch_r <= por_done | bod_done | pin_done;
        end
    end

    // power control: cold indicator survives warm resets
    always_ff @(posedge clock_i) begin
        if (rst_i || state_r == ST_POR) begin
            pwr_ctrl_r <= REG_RESET;
        end else if (por_done) begin
            pwr_ctrl_r <= COLD_MASK;
        end else if (in_reset) begin
            pwr_ctrl_r <= pwr_ctrl_r & COLD_MASK;
        end else if (wr_ok && reg_addr_i == ADDR_POWER_CONTROL) begin
            pwr_ctrl_r <= reg_wdata_i & PWR_WMASK;
        end
    end

    // auxiliary one: pin reset indicator, software may only clear it
    always_ff @(posedge clock_i) begin
        if (rst_i || state_r == ST_POR) begin
            aux_r <= REG_RESET;
        end else if (pin_done) begin
            aux_r <= PINF_MASK;
        end else if (in_reset) begin
            aux_r <= aux_r & PINF_MASK;
        end else if (wr_ok && reg_addr_i == ADDR_AUX_ONE) begin
            aux_r <= (reg_wdata_i & AUX_WMASK) | (aux_r & reg_wdata_i & PINF_MASK);
        end
    end

    // brown-out control zero: configuration reload during every reset
    always_comb begin
        bod_flag_keep = bod_r[BOD_FLAG_BIT];
        if (state_r == ST_POR) begin
            bod_flag_keep = 1'b0;
        end else if (bod_done) begin
            bod_flag_keep = 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            bod_r <= REG_RESET;
        end else if (in_reset) begin
            bod_r[BOD_EN_BIT]             <= cfg_s[BOD_EN_BIT];
            bod_r[LVL_HI_BIT:LVL_LO_BIT]  <= cfg_s[LVL_HI_BIT:LVL_LO_BIT];
            bod_r[BOF_BIT]                <= cfg_s[BOD_EN_BIT] & ~cfg_s[RST_EN_BIT] & below_s;
            bod_r[RST_EN_BIT]             <= cfg_s[RST_EN_BIT];
            bod_r[BOD_FLAG_BIT]           <= bod_flag_keep;
            bod_r[BOS_BIT]                <= 1'b0;
        end else if (wr_ok && reg_addr_i == ADDR_BOD_ZERO) begin
            bod_r <= (reg_wdata_i & BOD_WMASK) | ({7'h00, bos} << BOF_BIT);
        end else begin
            bod_r[BOF_BIT] <= bod_r[BOF_BIT] | bos;
        end
    end

    // interrupt status, write one to clear, set wins
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            below_d_r <= 1'b0;
        end else begin
            below_d_r <= below_s;
        end
    end

    always_comb begin
        events                = IRQ_RESET;
        events[IRQ_COLD_BIT]  = por_done;
        events[IRQ_BOD_BIT]   = bod_done;
        events[IRQ_PIN_BIT]   = pin_done;
        events[IRQ_LEVEL_BIT] = bod_r[BOD_EN_BIT] & below_s & ~below_d_r;
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            status_r <= IRQ_RESET;
        end else if (wr_ok && reg_addr_i == ADDR_IRQ_STATUS) begin
            status_r <= (status_r & ~reg_wdata_i[IRQ_W-1:0]) | events;
        end else begin
            status_r <= status_r | events;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            mask_r <= IRQ_RESET;
        end else if (wr_ok && reg_addr_i == ADDR_IRQ_MASK) begin
            mask_r <= reg_wdata_i[IRQ_W-1:0];
        end
    end

    // read data one cycle after the strobe
    always_ff @(posedge clock_i) begin
        if (rst_i || !reg_read_i) begin
            rdata_r <= REG_RESET;
        end else begin
            case (reg_addr_i)
                ADDR_POWER_CONTROL: rdata_r <= pwr_ctrl_r;
                ADDR_AUX_ONE:       rdata_r <= aux_r;
                ADDR_BOD_ZERO:      rdata_r <= bod_r | {7'h00, bos};
                ADDR_IRQ_STATUS:    rdata_r <= {4'h0, status_r};
                ADDR_IRQ_MASK:      rdata_r <= {4'h0, mask_r};
                default:            rdata_r <= REG_RESET;
            endcase
        end
    end

    assign reg_rdata_o        = rdata_r;
    assign irq_o              = |(status_r & mask_r);
    assign core_reset_o       = in_reset;
    assign fetch_start_o      = fetch_r;
    assign restart_vector_o   = RESTART_VECTOR;
    assign powerdown_o        = pwr_ctrl_r[PD_BIT];
    assign oscillator_start_o = (state_r != ST_POR) && !(state_r == ST_RUN && pwr_ctrl_r[PD_BIT]);
    // raw pin path, acts while the system clock is stopped
    assign clock_restart_o    = pwr_ctrl_r[PD_BIT] & ~reset_pin_n_i;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    AST_POR_HOLD: assert property (
        !supply_ok_s |=> core_reset_o && !oscillator_start_o)
        else $error("core left reset with supply below threshold");

    AST_COLD_SET: assert property (
        (state_r == ST_OSC && clock_stable_s && supply_ok_s) |=> pwr_ctrl_r[COLD_BIT] && fetch_start_o)
        else $error("cold indicator not set at power-on completion");

    AST_COLD_KEPT: assert property (
        (state_r inside {ST_BOD, ST_PIN, ST_WAKE} && supply_ok_s) |=> $stable(pwr_ctrl_r[COLD_BIT]))
        else $error("cold indicator changed by warm reset");

    AST_WARM_CLEARS: assert property (
        (state_r == ST_PIN && supply_ok_s) |=> (pwr_ctrl_r & ~COLD_MASK) == REG_RESET)
        else $error("ordinary bits not cleared during warm reset");

    AST_BOD_TRIGGER: assert property (
        (state_r == ST_RUN && bod_trip && supply_ok_s) |=> state_r == ST_BOD ##1 core_reset_o)
        else $error("brown-out reset not taken");

    AST_BOD_GATED: assert property (
        (state_r == ST_RUN && !bod_r[RST_EN_BIT]) |=> state_r != ST_BOD)
        else $error("brown-out reset taken while disabled");

    AST_BOD_FLAG_SET: assert property (
        (state_r == ST_BOD && !below_s && supply_ok_s) |=> bod_r[BOD_FLAG_BIT] && fetch_start_o)
        else $error("brown-out indicator not set");

    AST_PIN_ENTRY: assert property (
        (state_r == ST_RUN && !bod_trip && !pwr_ctrl_r[PD_BIT] && ps.pin_valid && supply_ok_s)
        |=> state_r == ST_PIN)
        else $error("qualified pin low did not reset");

    AST_PIN_HOLD: assert property (
        (state_r == ST_PIN && ps.pin_low) |=> core_reset_o)
        else $error("reset released while pin low");

    AST_WAKE_WAIT: assert property (
        (state_r == ST_WAKE && !clock_stable_s && supply_ok_s) |=> state_r == ST_WAKE)
        else $error("reset entered before clock stable");

    AST_PINF_SET: assert property (
        (state_r == ST_PIN && !ps.pin_low && supply_ok_s) |=> aux_r[PINF_BIT] ##1 !core_reset_o)
        else $error("pin reset indicator not set");

    AST_RELOAD: assert property (
        (in_reset && supply_ok_s) |=> bod_r[RST_EN_BIT] == $past(cfg_s[RST_EN_BIT])
            && bod_r[BOD_EN_BIT] == $past(cfg_s[BOD_EN_BIT]))
        else $error("configuration not reloaded during reset");

    AST_POR_CLEARS: assert property (
        (state_r == ST_POR) |=> !aux_r[PINF_BIT] && !bod_r[BOD_FLAG_BIT])
        else $error("cause flags not cleared by power-on");

    COV_COLD_BOOT: cover property (state_r == ST_OSC ##1 state_r == ST_RUN);
    COV_BOD_RESET: cover property (state_r == ST_BOD ##1 state_r == ST_RUN);
    COV_PIN_RESET: cover property (state_r == ST_PIN ##1 state_r == ST_RUN);
    COV_WAKE:      cover property (state_r == ST_WAKE ##1 state_r == ST_PIN);

endmodule
`default_nettype wire

// >>> verification/reset_board_model.sv
// board reset driver, supply monitor and oscillator model
`timescale 1ns/1ns
`default_nettype none
module reset_board_model #(
    parameter int OSC_SLOW = 12
) (
    // clock
    input  wire logic clock_i,
    // commands from the bench
    input  wire logic supply_on_i,
    input  wire logic brown_i,
    input  wire logic pin_req_i,
    input  wire logic pin_short_i,
    input  wire logic osc_slow_i,
    // from and towards the device
    input  wire logic oscillator_start_i,
    output logic      supply_above_por_o,
    output logic      supply_below_bod_o,
    output logic      reset_pin_n_o,
    output logic      clock_stable_o
);
    int low_cnt = 0;
    int osc_cnt = 0;

    initial begin
        supply_above_por_o = 1'b0;
        supply_below_bod_o = 1'b0;
        reset_pin_n_o = 1'b1;
        clock_stable_o = 1'b0;
    end

    always @(posedge clock_i) begin
        supply_above_por_o <= supply_on_i;
        supply_below_bod_o <= brown_i;
        // a request is stretched to the least valid low time
        if (pin_req_i || (!reset_pin_n_o && !pin_short_i && low_cnt < 24)) begin
            reset_pin_n_o <= 1'b0;
            low_cnt <= low_cnt + 1;
        end else begin
            reset_pin_n_o <= 1'b1;
            low_cnt <= 0;
        end
        // oscillator settles some cycles after it is started
        if (!oscillator_start_i) begin
            clock_stable_o <= 1'b0;
            osc_cnt <= 0;
        end else if (osc_cnt < (osc_slow_i ? OSC_SLOW : 2)) begin
            osc_cnt <= osc_cnt + 1;
        end else begin
            clock_stable_o <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// >>> verification/reset_source_controller_tb_top.sv
// self-checking bench of the reset source controller
`timescale 1ns/1ns
`default_nettype none
module reset_source_controller_tb_top;
    import rst_ctrl_pkg::*;

    logic        clock_i   = 1'b0;
    logic        rst_i     = 1'b1;
    logic        supply_on = 1'b0;
    logic        brown     = 1'b0;
    logic        pin_req   = 1'b0;
    logic        pin_short = 1'b0;
    logic        osc_slow  = 1'b0;
    logic [7:0]  cfg       = 8'h84;
    logic [7:0]  reg_addr  = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_write = 1'b0;
    logic        reg_read  = 1'b0;
    logic        above_por, below_bod, pin_n, clk_stable;
    logic        osc_start, clk_restart, core_reset, powerdown, fetch_start, irq;
    logic [15:0] restart_vector;
    logic [7:0]  reg_rdata;
    logic [7:0]  d;
    int          err_total = 0;
    int          cmp_count = 0;
    int          cycles    = 0;
    int          m_pwr, m_aux, m_bod;

    always #50 clock_i = ~clock_i;

    reset_source_controller reset_source_controller_i (
        .clock_i(clock_i), .rst_i(rst_i), .supply_above_por_i(above_por), .supply_below_bod_i(below_bod),
        .reset_pin_n_i(pin_n), .nonvolatile_config_byte_i(cfg), .clock_stable_i(clk_stable),
        .oscillator_start_o(osc_start), .clock_restart_o(clk_restart), .core_reset_o(core_reset),
        .powerdown_o(powerdown), .fetch_start_o(fetch_start), .restart_vector_o(restart_vector),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_write_i(reg_write), .reg_read_i(reg_read),
        .reg_rdata_o(reg_rdata), .irq_o(irq));

    reset_board_model reset_board_model_i (
        .clock_i(clock_i), .supply_on_i(supply_on), .brown_i(brown), .pin_req_i(pin_req),
        .pin_short_i(pin_short), .osc_slow_i(osc_slow), .oscillator_start_i(osc_start),
        .supply_above_por_o(above_por), .supply_below_bod_o(below_bod), .reset_pin_n_o(pin_n),
        .clock_stable_o(clk_stable));

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            end_of_test();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        cmp_count++;
        if (seen !== want) begin
            err_total++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock_i);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clock_i);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] m, input int want);
        @(posedge clock_i);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock_i);
        reg_read <= 1'b0;
        #1;
        chk(reg_rdata & m, want[7:0] & m);
    endtask

    task automatic wait_core(input int lim);
        int n;
        n = 0;
        while (core_reset !== 1'b1 && n < lim) begin
            tick(1);
            n++;
        end
        chk(core_reset, 1'b1);
    endtask

    task automatic wait_fetch();
        int n;
        n = 0;
        while (fetch_start !== 1'b1 && n < 80) begin
            tick(1);
            n++;
        end
        chk(fetch_start, 1'b1);
        chk(core_reset, 1'b0);
        chk(restart_vector, 16'h0000);
        tick(1);
        chk(fetch_start, 1'b0);
    endtask

    // reference flags after a power-on sequence
    task automatic m_cold();
        m_pwr = 8'h10;
        m_aux = 0;
        m_bod = cfg & 8'hf4;
    endtask

    // reference flags after a warm reset, src 0 pin, 1 brown-out
    task automatic m_warm(input int src);
        m_pwr = m_pwr & 8'h10;
        m_aux = m_aux & 8'h40;
        m_bod = (m_bod & 8'h02) | (cfg & 8'hf4);
        if (src == 0) begin
            m_aux = m_aux | 8'h40;
        end else begin
            m_bod = m_bod | 8'h02;
        end
    endtask

    task automatic check_regs();
        rd(ADDR_POWER_CONTROL, 8'hff, m_pwr);
        rd(ADDR_AUX_ONE, 8'hff, m_aux);
        rd(ADDR_BOD_ZERO, 8'hf6, m_bod);
    endtask

    task automatic pin_reset();
        pin_req <= 1'b1;
        wait_core(60);
        tick(30);
        chk(core_reset, 1'b1);
        pin_req <= 1'b0;
        wait_fetch();
        m_warm(0);
        check_regs();
    endtask

    initial begin
        void'($urandom(30));
        repeat (4) @(posedge clock_i);
        rst_i <= 1'b0;
        tick(10);
        chk(core_reset, 1'b1);
        chk(osc_start, 1'b0);
        supply_on <= 1'b1;
        wait_fetch();
        chk(osc_start, 1'b1);
        m_cold();
        check_regs();
        rd(8'h55, 8'hff, 0);
        rd(ADDR_IRQ_STATUS, 8'h01, 1);
        wr(ADDR_IRQ_MASK, 8'h01);
        tick(1);
        chk(irq, 1'b1);
        wr(ADDR_IRQ_STATUS, 8'h01);
        tick(1);
        chk(irq, 1'b0);
        repeat (8) begin
            d = 8'($urandom) & 8'hfd;
            wr(ADDR_POWER_CONTROL, d);
            m_pwr = d & 8'hdd;
            rd(ADDR_POWER_CONTROL, 8'hff, m_pwr);
            d = 8'($urandom);
            wr(ADDR_AUX_ONE, d);
            m_aux = (m_aux & d & 8'h40) | (d & 8'had);
            rd(ADDR_AUX_ONE, 8'hff, m_aux);
        end
        // software marks the next reset as warm
        wr(ADDR_POWER_CONTROL, 8'h00);
        m_pwr = 0;
        cfg <= 8'h80 | 8'(($urandom % 8) << 4);
        pin_reset();
        rd(ADDR_IRQ_STATUS, 8'h04, 4);
        pin_short <= 1'b1;
        pin_req <= 1'b1;
        tick(10);
        pin_req <= 1'b0;
        tick(40);
        chk(core_reset, 1'b0);
        pin_short <= 1'b0;
        brown <= 1'b1;
        tick(30);
        chk(core_reset, 1'b0);
        rd(ADDR_IRQ_STATUS, 8'h08, 8);
        brown <= 1'b0;
        tick(5);
        m_bod = m_bod | 8'h06;
        wr(ADDR_BOD_ZERO, 8'(m_bod));
        rd(ADDR_BOD_ZERO, 8'hf6, m_bod);
        brown <= 1'b1;
        wait_core(20);
        tick(10);
        brown <= 1'b0;
        wait_fetch();
        m_warm(1);
        check_regs();
        rd(ADDR_IRQ_STATUS, 8'h02, 2);
        m_bod = m_bod & 8'hfd;
        wr(ADDR_BOD_ZERO, 8'(m_bod));
        rd(ADDR_BOD_ZERO, 8'hf6, m_bod);
        wr(ADDR_POWER_CONTROL, 8'h02);
        tick(5);
        chk(powerdown, 1'b1);
        chk(osc_start, 1'b0);
        osc_slow <= 1'b1;
        pin_req <= 1'b1;
        tick(1);
        chk(clk_restart, 1'b1);
        wait_core(20);
        chk(osc_start, 1'b1);
        // power-down bit drops one cycle after the wake state is entered
        tick(1);
        chk(powerdown, 1'b0);
        pin_reset();
        supply_on <= 1'b0;
        wait_core(20);
        tick(10);
        supply_on <= 1'b1;
        wait_fetch();
        m_cold();
        check_regs();
        end_of_test();
    end
endmodule
`default_nettype wire
